// ### design/dsdma_pkg.sv
// package: address map, opcodes and sizes for the dual-space data access block
package dsdma_pkg;
    // ******************************************************
    // address map (fixed in hardware)
    // ******************************************************
    localparam logic [15:0] SFR_BASE = 16'h0000;
    localparam logic [15:0] SFR_LAST = 16'h07ff;
    localparam logic [15:0] XRAM_BASE = 16'h0800;
    localparam logic [15:0] XRAM_LAST = 16'h0bff;
    localparam logic [15:0] YRAM_BASE = 16'h0c00;
    localparam logic [15:0] YRAM_LAST = 16'h0fff;
    localparam logic [15:0] NEAR_LAST = 16'h1fff;
    localparam int NEAR_ADDR_W = 13;
    localparam int RAM_WORDS = 1024;
    localparam int SFR_WORDS = 1024;
    localparam int PSV_PAGE_W = 8;
    localparam int PSV_OFFS_W = 15;
    localparam int EA_PSV_BIT = 15;
    // ******************************************************
    // post-modify steps and reset values
    // ******************************************************
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // ******************************************************
    // operation classes, addressing modes and extension kinds
    // ******************************************************
    typedef enum logic [3:0] {
        DSDMA_OP_OTHER, DSDMA_OP_CLR, DSDMA_OP_ED, DSDMA_OP_EUCLID_DISTANCE_ACCUMULATE_OP, DSDMA_OP_MAC,
        DSDMA_OP_ACCUMULATOR_PREFETCH_MOVE_OP, DSDMA_OP_MPY, DSDMA_OP_MPYN, DSDMA_OP_MSC
    } dsdma_op_t;
    typedef enum logic [1:0] {
        DSDMA_ADDR_INDIRECT, DSDMA_ADDR_NEAR, DSDMA_ADDR_MOVFULL
    } dsdma_amode_t;
    typedef enum logic [1:0] {
        DSDMA_EXT_NONE, DSDMA_EXT_SIGN, DSDMA_EXT_ZERO
    } dsdma_ext_t;
endpackage

// ### design/dsdma_core.sv
// design: dual-space data memory access logic of a 16-bit signal controller core
// Contract
// - outside prefetch class the whole 64-Kbyte space is one X space.
// - prefetch reads reach Y only through Y pointers, the rest through X pointers.
// - simultaneous X and Y reads only for the prefetch class.
// - separate X read and write buses; all writes use the X write bus.
// - no writes on Y bus; accumulator write-back uses X bus, any address.
// - bit-reversed addressing only for X space writes.
// - modulo addressing works for Y prefetches and X accesses.
// - unimplemented or out-of-space addresses return zero.
// - X pointer into Y region during prefetch gives zero.
// - Y pointer into X space during prefetch gives zero.
// - X/Y boundary fixed in hardware.
// - 16-bit byte effective addresses, 64 Kbytes, 16-bit byte-addressable words.
// - byte read selects byte by bit 0 onto low lane.
// - Y path fetches words only.
// - byte write asserts only the matching byte write line.
// - post-modify step is 1 for bytes, 2 for words.
// - odd word access traps; faulting write does not store.
// - byte loads into working registers change only the low byte.
// - sign-extend and zero-extend operations on register data.
// - near direct addressing reaches 0x0000-0x1FFF with 13-bit field.
// - full-width direct move addressing reaches all of X space.
// - eight dual-operand instructions form the prefetch class.
// - EA bit 15 with visibility enabled redirects reads into program page.
`timescale 1ns/1ps
`default_nettype none
module dsdma_core
    import dsdma_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // access request from the pipeline
    input wire logic REQ_VALID,
    input wire dsdma_pkg::dsdma_op_t OP_CLASS,
    input wire dsdma_pkg::dsdma_amode_t ADDR_MODE,
    input wire logic REQ_WRITE,
    input wire logic REQ_BYTE,
    input wire logic [15:0] REQ_EA,
    input wire logic [15:0] WRITE_DATA,
    input wire logic BIT_REVERSE,
    input wire logic MODULO_EN,
    input wire logic [15:0] MOD_START,
    input wire logic [15:0] MOD_END,
    // prefetch pointers
    input wire logic X_PTR_SEL,
    input wire logic Y_PTR_SEL,
    input wire logic [15:0] X_PREFETCH_PTR_0,
    input wire logic [15:0] X_PREFETCH_PTR_1,
    input wire logic [15:0] Y_PREFETCH_PTR_0,
    input wire logic [15:0] Y_PREFETCH_PTR_1,
    // working register byte load and extension
    input wire dsdma_pkg::dsdma_ext_t EXT_OP,
    input wire logic [15:0] DEST_REG_OLD,
    // program space visibility
    input wire logic PROGRAM_VISIBILITY_ENABLE,
    input wire logic [7:0] PSV_PAGE,
    input wire logic [15:0] PROG_RDATA,
    // results
    output logic [15:0] X_READ_DATA,
    output logic [15:0] Y_READ_DATA,
    output logic READ_VALID,
    output logic [15:0] DEST_REG_NEW,
    output logic [15:0] NEXT_POINTER,
    output logic [15:0] X_PTR_NEXT,
    output logic [15:0] Y_PTR_NEXT,
    output logic ADDR_ERROR_TRAP,
    output logic [22:0] PROG_ADDR,
    output logic PROG_RD
);
    // ******************************************************
    // storage: SFR area and data RAM as two byte halves
    // ******************************************************
    logic [7:0] mem_lo [0:SFR_WORDS+RAM_WORDS-1];
    logic [7:0] mem_hi [0:SFR_WORDS+RAM_WORDS-1];

    // ******************************************************
    // decode
    // ******************************************************
    logic dual_op;
    logic [15:0] x_ea;
    logic [15:0] y_ea;
    logic x_in_y;
    logic x_impl;
    logic y_impl;
    logic x_psv;
    logic misalign;
    logic we_lo;
    logic we_hi;
    logic [10:0] x_widx;
    logic [10:0] y_widx;
    logic [15:0] x_word;
    logic [15:0] y_word;
    logic [15:0] x_rd;
    logic [15:0] step;
    logic [15:0] rd_raw;
    logic rd_lane;
    logic rd_byte;
    // psv read: address leaves registered, so program data is taken one cycle later
    logic psv_pend;
    logic psv_lane;
    logic psv_byte;

    function automatic logic [15:0] bitrev(input logic [15:0] a);
        logic [15:0] r;
        r = ZERO_WORD;
        for (int i = 1; i < 16; i++) begin
            r[i] = a[16-i];
        end
        return r;
    endfunction

    function automatic logic [15:0] modwrap(input logic [15:0] p, input logic [15:0] s,
            input logic en, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] n;
        n = p + s;
        if (en && p >= lo && p <= hi && n > hi) begin
            n = lo + (n - hi - STEP_BYTE);
        end
        return n;
    endfunction

    always_comb begin
        // prefetch class is the eight dual-operand opcodes
        // undefined opcode values stay single-path
        dual_op = (OP_CLASS inside {DSDMA_OP_CLR, DSDMA_OP_ED, DSDMA_OP_EUCLID_DISTANCE_ACCUMULATE_OP, DSDMA_OP_MAC,
            DSDMA_OP_ACCUMULATOR_PREFETCH_MOVE_OP, DSDMA_OP_MPY, DSDMA_OP_MPYN, DSDMA_OP_MSC}) && !REQ_WRITE;
        x_ea = REQ_EA;
        if (ADDR_MODE == DSDMA_ADDR_NEAR) begin
            x_ea = {3'h0, REQ_EA[NEAR_ADDR_W-1:0]};
        end
        if (dual_op) begin
            x_ea = X_PTR_SEL ? X_PREFETCH_PTR_1 : X_PREFETCH_PTR_0;
        end
        if (REQ_WRITE && BIT_REVERSE) begin
            x_ea = bitrev(REQ_EA); // reversed only on X writes
        end
        y_ea = Y_PTR_SEL ? Y_PREFETCH_PTR_1 : Y_PREFETCH_PTR_0;
        // boundary is constant compare, nothing moves it
        x_in_y = x_ea >= YRAM_BASE && x_ea <= YRAM_LAST;
        x_psv = x_ea[EA_PSV_BIT] && PROGRAM_VISIBILITY_ENABLE && !REQ_WRITE;
        // full 64K is one X space outside the class
        x_impl = (x_ea <= YRAM_LAST) && !(dual_op && x_in_y);
        y_impl = y_ea >= YRAM_BASE && y_ea <= YRAM_LAST;
        misalign = REQ_VALID && !REQ_BYTE && (dual_op ? (x_ea[0] | y_ea[0]) : x_ea[0]);
        x_widx = x_ea[11:1]; // word index, byte in bit 0
        y_widx = y_ea[11:1];
        // no write ever through Y; write lines per byte half
        we_lo = REQ_VALID && REQ_WRITE && !misalign && x_impl && (!REQ_BYTE || !x_ea[0]);
        we_hi = REQ_VALID && REQ_WRITE && !misalign && x_impl && (!REQ_BYTE || x_ea[0]);
        x_word = {mem_hi[x_widx], mem_lo[x_widx]};
        y_word = {mem_hi[y_widx], mem_lo[y_widx]};
        // program data belongs to the registered page address
        if (psv_pend) begin
            rd_raw = PROG_RDATA;
            rd_lane = psv_lane;
            rd_byte = psv_byte;
        end else begin
            rd_raw = x_impl ? x_word : ZERO_WORD;
            rd_lane = x_ea[0];
            rd_byte = REQ_BYTE;
        end
        x_rd = rd_raw;
        if (rd_byte) begin
            x_rd = {8'h00, rd_lane ? rd_raw[15:8] : rd_raw[7:0]};
        end
        step = REQ_BYTE ? STEP_BYTE : STEP_WORD;
    end

    // ******************************************************
    // next register values
    // ******************************************************
    logic [15:0] next_x_read_data;
    logic [15:0] next_y_read_data;
    logic next_read_valid;
    logic [15:0] next_dest_reg_new;
    logic [15:0] next_next_pointer;
    logic [15:0] next_x_ptr_next;
    logic [15:0] next_y_ptr_next;
    logic next_addr_error_trap;
    logic [22:0] next_prog_addr;
    logic next_prog_rd;
    logic next_psv_pend;
    logic next_psv_lane;
    logic next_psv_byte;

    always_comb begin
        // a psv read answers one cycle late; the pipeline keeps that cycle idle
        next_read_valid = psv_pend || (REQ_VALID && !REQ_WRITE && !x_psv);
        next_x_read_data = next_read_valid ? x_rd : ZERO_WORD;
        // Y path only for the class, words only
        next_y_read_data = (REQ_VALID && dual_op && y_impl) ? y_word : ZERO_WORD;
        next_dest_reg_new = DEST_REG_OLD;
        unique case (EXT_OP)
            DSDMA_EXT_SIGN: next_dest_reg_new = {{8{DEST_REG_OLD[7]}}, DEST_REG_OLD[7:0]};
            DSDMA_EXT_ZERO: next_dest_reg_new = {8'h00, DEST_REG_OLD[7:0]};
            DSDMA_EXT_NONE: begin
                if (next_read_valid) begin
                    // byte load keeps the high byte
                    next_dest_reg_new = rd_byte ? {DEST_REG_OLD[15:8], x_rd[7:0]} : x_rd;
                end
            end
            default: next_dest_reg_new = DEST_REG_OLD;
        endcase
        next_next_pointer = modwrap(REQ_EA, step, MODULO_EN, MOD_START, MOD_END);
        // circular buffers apply to both prefetch pointers
        next_x_ptr_next = modwrap(x_ea, STEP_WORD, MODULO_EN, MOD_START, MOD_END);
        next_y_ptr_next = modwrap(y_ea, STEP_WORD, MODULO_EN, MOD_START, MOD_END);
        next_addr_error_trap = misalign;
        next_prog_addr = {PSV_PAGE, x_ea[PSV_OFFS_W-1:0]};
        next_prog_rd = REQ_VALID && x_psv;
        next_psv_pend = REQ_VALID && x_psv;
        next_psv_lane = x_ea[0];
        next_psv_byte = REQ_BYTE;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            X_READ_DATA <= ZERO_WORD;
            Y_READ_DATA <= ZERO_WORD;
            READ_VALID <= 1'b0;
            DEST_REG_NEW <= ZERO_WORD;
            NEXT_POINTER <= ZERO_WORD;
            X_PTR_NEXT <= ZERO_WORD;
            Y_PTR_NEXT <= ZERO_WORD;
            ADDR_ERROR_TRAP <= 1'b0;
            PROG_ADDR <= 23'h000000;
            PROG_RD <= 1'b0;
            psv_pend <= 1'b0;
            psv_lane <= 1'b0;
            psv_byte <= 1'b0;
        end else begin
            X_READ_DATA <= next_x_read_data;
            Y_READ_DATA <= next_y_read_data;
            READ_VALID <= next_read_valid;
            DEST_REG_NEW <= next_dest_reg_new;
            NEXT_POINTER <= next_next_pointer;
            X_PTR_NEXT <= next_x_ptr_next;
            Y_PTR_NEXT <= next_y_ptr_next;
            ADDR_ERROR_TRAP <= next_addr_error_trap;
            PROG_ADDR <= next_prog_addr;
            PROG_RD <= next_prog_rd;
            psv_pend <= next_psv_pend;
            psv_lane <= next_psv_lane;
            psv_byte <= next_psv_byte;
        end
    end

    // memory has no reset; writes only on the X write bus
    always_ff @(posedge SYS_CLK) begin
        if (we_lo) begin
            mem_lo[x_widx] <= WRITE_DATA[7:0];
        end
        if (we_hi) begin
            mem_hi[x_widx] <= REQ_BYTE ? WRITE_DATA[7:0] : WRITE_DATA[15:8];
        end
    end

    // ******************************************************
    // checks
    // ******************************************************
    property p_trap_pulse;
        @(posedge SYS_CLK) disable iff (!RST_N) ADDR_ERROR_TRAP |-> $past(misalign);
    endproperty
    a_trap_pulse: assert property (p_trap_pulse) else $error("trap without misalign");

    property p_no_store_on_fault;
        @(posedge SYS_CLK) disable iff (!RST_N) misalign |-> !(we_lo || we_hi);
    endproperty
    a_no_store_on_fault: assert property (p_no_store_on_fault) else $error("faulting write stored");

    property p_byte_one_lane;
        @(posedge SYS_CLK) disable iff (!RST_N) (REQ_BYTE && REQ_WRITE) |-> !(we_lo && we_hi);
    endproperty
    a_byte_one_lane: assert property (p_byte_one_lane) else $error("byte write hit both halves");

    property p_byte_low_lane;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (REQ_VALID && !REQ_WRITE && REQ_BYTE && EXT_OP == DSDMA_EXT_NONE) |=> X_READ_DATA[15:8] == 8'h00;
    endproperty
    a_byte_low_lane: assert property (p_byte_low_lane) else $error("byte read high lane not zero");

    property p_y_only_class;
        @(posedge SYS_CLK) disable iff (!RST_N) !dual_op |=> Y_READ_DATA == ZERO_WORD;
    endproperty
    a_y_only_class: assert property (p_y_only_class) else $error("Y read outside class");

    property p_x_in_y_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (REQ_VALID && dual_op && x_in_y && !x_psv && REQ_BYTE == 1'b0) |=> X_READ_DATA == ZERO_WORD;
    endproperty
    a_x_in_y_zero: assert property (p_x_in_y_zero) else $error("X pointer into Y not zero");

    property p_y_out_zero;
        @(posedge SYS_CLK) disable iff (!RST_N) (REQ_VALID && dual_op && !y_impl) |=> Y_READ_DATA == ZERO_WORD;
    endproperty
    a_y_out_zero: assert property (p_y_out_zero) else $error("Y pointer outside Y not zero");

    property p_step;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (!MODULO_EN && REQ_BYTE) |=> NEXT_POINTER == $past(REQ_EA) + STEP_BYTE;
    endproperty
    a_step: assert property (p_step) else $error("byte step wrong");

    property p_unimpl_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (REQ_VALID && !REQ_WRITE && !x_psv && x_ea > YRAM_LAST) |=> X_READ_DATA == ZERO_WORD;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");

    property p_psv_late;
        @(posedge SYS_CLK) disable iff (!RST_N)
            (REQ_VALID && x_psv && !psv_pend) |=> (PROG_RD && !READ_VALID) ##1 READ_VALID;
    endproperty
    a_psv_late: assert property (p_psv_late) else $error("program data not one cycle late");

    c_dual: cover property (@(posedge SYS_CLK) disable iff (!RST_N) REQ_VALID && dual_op && y_impl);
    c_trap: cover property (@(posedge SYS_CLK) disable iff (!RST_N) ADDR_ERROR_TRAP);
    c_psv: cover property (@(posedge SYS_CLK) disable iff (!RST_N) PROG_RD);
    c_bytewr: cover property (@(posedge SYS_CLK) disable iff (!RST_N) we_hi && REQ_BYTE);
endmodule
`default_nettype wire

// ### verif/dsdma_agu_model.sv
// partner model: the address generation side that issues access requests
`timescale 1ns/1ps
`default_nettype none
module dsdma_agu_model (
    // clock
    input wire logic clk,
    // request
    output var logic req_valid,
    output var dsdma_pkg::dsdma_op_t op_class,
    output var logic req_write,
    output var logic req_byte,
    output var logic [15:0] req_ea,
    output var logic [15:0] write_data,
    // static setup
    output var dsdma_pkg::dsdma_amode_t addr_mode,
    output var dsdma_pkg::dsdma_ext_t ext_op,
    output var logic bit_reverse,
    output var logic modulo_en,
    output var logic [31:0] mod_bounds,
    output var logic [1:0] ptr_sel,
    output var logic [63:0] ptrs,
    output var logic [15:0] dest_old,
    output var logic [8:0] program_visibility_enable,
    // program memory
    input wire logic [22:0] prog_addr,
    output logic [15:0] prog_rdata
);
    import dsdma_pkg::*;
    // low 16 address bits xor 0x5a5a as content, so a wrong offset shows up
    assign prog_rdata = prog_addr[15:0] ^ 16'h5a5a;
    initial begin
        req_valid = 1'b0;
        op_class = DSDMA_OP_OTHER;
        req_write = 1'b0;
        req_byte = 1'b0;
        req_ea = 16'h0000;
        write_data = 16'h0000;
        addr_mode = DSDMA_ADDR_INDIRECT;
        ext_op = DSDMA_EXT_NONE;
        bit_reverse = 1'b0;
        modulo_en = 1'b0;
        mod_bounds = 32'h0;
        ptr_sel = 2'h0;
        ptrs = 64'h0;
        dest_old = 16'h0000;
        program_visibility_enable = 9'h000;
    end
    // ******************************************************
    // request and setup cycles
    // ******************************************************
    // held from a falling edge through the taking rising edge; returns with outputs settled
    task automatic access(input dsdma_op_t op, input logic wr, input logic byt, input logic [15:0] ea,
                          input logic [15:0] wd = 16'h0000);
        @(negedge clk);
        req_valid = 1'b1;
        op_class = op;
        req_write = wr;
        req_byte = byt;
        req_ea = ea;
        write_data = wd;
        @(posedge clk);
        #2;
    endtask
    // setup only changes in an idle cycle, never under a standing request
    task automatic setup(input dsdma_amode_t am = DSDMA_ADDR_INDIRECT, input dsdma_ext_t ex = DSDMA_EXT_NONE,
                         input logic br = 1'b0, input logic me = 1'b0, input logic [31:0] mb = 32'h0,
                         input logic [1:0] ps = 2'h0, input logic [63:0] pv = 64'h0,
                         input logic [15:0] old = 16'h0000, input logic [8:0] pg = 9'h000);
        @(negedge clk);
        req_valid = 1'b0;
        addr_mode = am;
        ext_op = ex;
        bit_reverse = br;
        modulo_en = me;
        mod_bounds = mb;
        ptr_sel = ps;
        ptrs = pv;
        dest_old = old;
        program_visibility_enable = pg;
        @(posedge clk);
        #2;
    endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// testbench: directed scenarios for the dual-space data access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dsdma_pkg::*;
    logic sys_clk;
    logic rst_n;
    int miscompares;
    int samples_checked;
    int cycles;
    logic rv, rw, rb, br, me, rd_valid, trap, prog_rd;
    dsdma_op_t opc;
    dsdma_amode_t am;
    dsdma_ext_t ex;
    logic [15:0] ea, wd, old, pdat, x_rd, y_rd, dest_new, next_ptr, x_next, y_next;
    logic [31:0] mb;
    logic [1:0] ps;
    logic [63:0] pv;
    logic [8:0] pg;
    logic [22:0] prog_addr;
    dsdma_agu_model i_agu (.clk(sys_clk), .req_valid(rv), .op_class(opc), .req_write(rw), .req_byte(rb),
        .req_ea(ea), .write_data(wd), .addr_mode(am), .ext_op(ex), .bit_reverse(br), .modulo_en(me),
        .mod_bounds(mb), .ptr_sel(ps), .ptrs(pv), .dest_old(old), .program_visibility_enable(pg), .prog_addr(prog_addr),
        .prog_rdata(pdat));
    dsdma_core i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REQ_VALID(rv), .OP_CLASS(opc), .ADDR_MODE(am),
        .REQ_WRITE(rw), .REQ_BYTE(rb), .REQ_EA(ea), .WRITE_DATA(wd), .BIT_REVERSE(br), .MODULO_EN(me),
        .MOD_START(mb[31:16]), .MOD_END(mb[15:0]), .X_PTR_SEL(ps[0]), .Y_PTR_SEL(ps[1]),
        .X_PREFETCH_PTR_0(pv[15:0]), .X_PREFETCH_PTR_1(pv[31:16]), .Y_PREFETCH_PTR_0(pv[47:32]),
        .Y_PREFETCH_PTR_1(pv[63:48]), .EXT_OP(ex), .DEST_REG_OLD(old), .PROGRAM_VISIBILITY_ENABLE(pg[8]),
        .PSV_PAGE(pg[7:0]), .PROG_RDATA(pdat), .X_READ_DATA(x_rd), .Y_READ_DATA(y_rd), .READ_VALID(rd_valid),
        .DEST_REG_NEW(dest_new), .NEXT_POINTER(next_ptr), .X_PTR_NEXT(x_next), .Y_PTR_NEXT(y_next),
        .ADDR_ERROR_TRAP(trap), .PROG_ADDR(prog_addr), .PROG_RD(prog_rd));
    // ******************************************************
    // clock, timeout, report
    // ******************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ******************************************************
    // scenarios
    // ******************************************************
    task automatic t_word_rw;
        i_agu.setup();
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h0800, 16'h1234);
        chk("word step", 16'h0802, next_ptr);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0800);
        chk("word read", 16'h1234, x_rd);
        chk("read valid", 16'h0001, {15'h0, rd_valid});
        chk("single path", 16'h0000, y_rd);
    endtask
    task automatic t_bytes;
        dsdma_ext_t kinds [3];
        logic [15:0] want [3];
        kinds = '{DSDMA_EXT_NONE, DSDMA_EXT_SIGN, DSDMA_EXT_ZERO};
        want = '{16'h34a5, 16'hff81, 16'h0081};
        i_agu.setup();
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b1, 16'h0802, 16'h005a);
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b1, 16'h0803, 16'h00a5);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0802);
        chk("byte lanes", 16'ha55a, x_rd);
        for (int i = 0; i < 3; i++) begin
            i_agu.setup(.ex(kinds[i]), .old(16'h3481));
            i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b1, 16'h0803);
            chk("byte read", 16'h00a5, x_rd);
            chk("byte step", 16'h0804, next_ptr);
            chk("dest reg", want[i], dest_new);
        end
    endtask
    task automatic t_trap;
        i_agu.setup();
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h0804, 16'h1111);
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h0805, 16'hdead);
        chk("odd write trap", 16'h0001, {15'h0, trap});
        i_agu.setup();
        chk("trap pulse", 16'h0000, {15'h0, trap});
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0804);
        chk("no store", 16'h1111, x_rd);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0807);
        chk("odd read trap", 16'h0001, {15'h0, trap});
    endtask
    task automatic t_space;
        i_agu.setup();
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h0c00, 16'h7777);
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h1000, 16'hffff);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0c00);
        chk("y via x path", 16'h7777, x_rd);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h1000);
        chk("unimplemented", 16'h0000, x_rd);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h8000);
        chk("upper half off", 16'h0000, x_rd);
    endtask
    task automatic t_dual;
        i_agu.setup(.pv({16'h0800, 16'h0c00, 16'h0c00, 16'h0800}));
        for (int i = 1; i < 9; i++) begin
            i_agu.access(dsdma_op_t'(i), 1'b0, 1'b0, 16'h0000);
            chk("x operand", 16'h1234, x_rd);
            chk("y operand", 16'h7777, y_rd);
            chk("x step", 16'h0802, x_next);
            chk("y step", 16'h0c02, y_next);
        end
        i_agu.setup(.ps(2'b11), .pv({16'h0800, 16'h0c00, 16'h0c00, 16'h0800}));
        i_agu.access(DSDMA_OP_MAC, 1'b0, 1'b0, 16'h0000);
        chk("x ptr in y", 16'h0000, x_rd);
        chk("y ptr in x", 16'h0000, y_rd);
        i_agu.setup(.me(1'b1), .mb({16'h0c00, 16'h0c0f}), .pv({16'h0800, 16'h0c0e, 16'h0c00, 16'h0800}));
        i_agu.access(DSDMA_OP_MAC, 1'b0, 1'b0, 16'h0000);
        chk("y wrap", 16'h0c00, y_next);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0c0e);
        chk("x wrap", 16'h0c00, next_ptr);
    endtask
    task automatic t_modes;
        i_agu.setup(.am(DSDMA_ADDR_NEAR));
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'he800);
        chk("near field", 16'h1234, x_rd);
        i_agu.setup(.am(DSDMA_ADDR_MOVFULL));
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0c00);
        chk("full direct", 16'h7777, x_rd);
        i_agu.setup();
        // reversal moves EA bit 5 onto bit 11, so a write to 0x0020 lands at 0x0800
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h0020, 16'h0101);
        i_agu.setup(.br(1'b1));
        i_agu.access(DSDMA_OP_OTHER, 1'b1, 1'b0, 16'h0020, 16'h4321);
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0020);
        chk("no reverse read", 16'h0101, x_rd);
        i_agu.setup();
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h0800);
        chk("reversed write", 16'h4321, x_rd);
        i_agu.setup(.pg(9'h13c));
        i_agu.access(DSDMA_OP_OTHER, 1'b0, 1'b0, 16'h8204);
        chk("prog page", 16'h003c, {8'h00, prog_addr[22:15]});
        chk("prog offset", 16'h0204, {1'b0, prog_addr[14:0]});
        chk("prog read", 16'h0001, {15'h0, prog_rd});
        // program content is its address xor 0x5a5a: 0x0204 gives 0x585e one cycle later
        i_agu.setup();
        chk("prog data", 16'h585e, x_rd);
        chk("prog data valid", 16'h0001, {15'h0, rd_valid});
    endtask
    initial begin
        rst_n = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge sys_clk);
        chk("reset valid", 16'h0000, {15'h0, rd_valid});
        chk("reset trap", 16'h0000, {15'h0, trap});
        @(negedge sys_clk);
        rst_n = 1'b1;
        t_word_rw();
        t_bytes();
        t_trap();
        t_space();
        t_dual();
        t_modes();
        i_agu.setup();
        tally_and_finish();
    end
endmodule
`default_nettype wire
